// [tb/mcsd_decode_tb_top.sv]
// Self-checking bench for the midrange chip select decoder
`timescale 1ns/1ps
`default_nettype none

module mcsd_decode_tb_top;
    logic mclk_in, rst_in, wr, rd, cs, cm, ce, frz, pbv, lcw, rdy, mdone, udone, lse;
    logic [7:0] ra;
    logic [15:0] wd, rdo, rdat;
    logic [19:0] ca;
    logic [8:0] pbase;
    logic [3:0] msel, sel, dly;
    logic [1:0] upo, up;
    int fail_count, checks, md, ud;

    mcsd_decode dut (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(ra),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdo),
        .cyc_start_in(cs), .cyc_addr_in(ca), .cyc_mem_in(cm), .cyc_end_in(ce),
        .full_range_select_zero_in(frz), .peripheral_base_in(pbase),
        .peripheral_base_valid_in(pbv), .lower_config_write_in(lcw), .ext_ready_in(rdy),
        .midrange_selects_n_out(msel), .upper_peripheral_selects_out(upo),
        .lower_select_enable_out(lse), .mid_done_out(mdone), .upper_done_out(udone));
    mcsd_partner mem (.mclk_in(mclk_in), .rst_in(rst_in), .sel_n_in(msel),
        .delay_in(dly), .ready_out(rdy));

    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        wr <= 1'b1;
        ra <= a;
        wd <= d;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a);
        @(posedge mclk_in);
        rd <= 1'b1;
        ra <= a;
        @(posedge mclk_in);
        rd <= 1'b0;
        @(negedge mclk_in);
        rdat = rdo;
    endtask

    task automatic mid(input logic [19:0] b, input logic [2:0] rw);
        wreg(8'hA8 - 8'h02, {b[19:13], 6'h3F, rw});
    endtask

    task automatic aux(input logic [6:0] code, input logic [1:0] exms, input logic [2:0] rw);
        wreg(8'hA8, {1'b1, code, exms, 3'b111, rw});
    endtask

    // One bus cycle: start c0, selects seen in c2, end in c15
    task automatic cyc(input logic [19:0] a, input logic m);
        md = 0;
        ud = 0;
        @(posedge mclk_in);
        cs <= 1'b1;
        ca <= a;
        cm <= m;
        for (int i = 1; i <= 16; i++) begin
            @(posedge mclk_in);
            cs <= 1'b0;
            ce <= (i == 15);
            @(negedge mclk_in);
            if (i == 2) begin
                sel = msel;
                up = upo;
            end
            if (mdone === 1'b1 && md == 0) md = i;
            if (udone === 1'b1 && ud == 0) ud = i;
        end
        chk("release", 16'hF, 16'(msel));
    endtask

    task automatic t_reset;
        rreg(8'hA6);
        chk("mid reset", 16'h01F8, rdat);
        @(negedge mclk_in);
        chk("rdata idle", 16'h0, rdo);
        rreg(8'hA8);
        chk("aux reset", 16'h8038, rdat);
        wreg(8'h40, 16'h1234);
        rreg(8'h40);
        chk("unmapped", 16'h0, rdat);
        cyc(20'h02000, 1'b1);
        chk("sel unconfigured", 16'hF, 16'(sel));
        mid(20'h02000, 3'b100);
        cyc(20'h02000, 1'b1);
        chk("sel mid only", 16'hF, 16'(sel));
        rreg(8'hAA);
        chk("status mid only", 16'h0001, rdat);
        $display("reset test done");
    endtask

    task automatic t_sizes;
        logic [19:0] sz, b;
        for (int k = 0; k < 7; k++) begin
            sz = 20'h02000 << k;
            b = (k == 6) ? 20'h0 : sz;
            mid(b, 3'b100);
            aux(7'h01 << k, 2'b00, 3'b100);
            for (int q = 0; q < 4; q++) begin
                cyc(b + (sz >> 2) * 20'(q + 1) - 20'h1, 1'b1);
                chk("quarter", {12'h000, ~(4'h1 << q)}, 16'(sel));
                chk("mid done", 16'h3, 16'(md));
            end
            cyc(b + sz, 1'b1);
            chk("beyond block", 16'hF, 16'(sel));
        end
        cyc(20'h00010, 1'b0);
        chk("io cycle", 16'hF, 16'(sel));
        $display("size test done");
    endtask

    task automatic t_full;
        mid(20'h08000, 3'b100);
        aux(7'h04, 2'b00, 3'b111);
        @(posedge mclk_in);
        frz <= 1'b1;
        cyc(20'h0C123, 1'b1);
        chk("full q2", 16'hA, 16'(sel));
        cyc(20'h0E000, 1'b1);
        chk("full q3", 16'h6, 16'(sel));
        @(posedge mclk_in);
        frz <= 1'b0;
        $display("full range test done");
    endtask

    task automatic t_waits;
        for (int w = 0; w < 4; w++) begin
            mid(20'h08000, {1'b1, 2'(w)});
            cyc(20'h08000, 1'b1);
            chk("mid waits", 16'(3 + w), 16'(md));
        end
        mid(20'h08000, 3'b000);
        dly <= 4'h6;
        cyc(20'h08000, 1'b1);
        chk("slow ready", 16'h1, 16'(md > 6));
        dly <= 4'h0;
        // Stale ready of the slow access must drain through the synchroniser
        repeat (4) @(posedge mclk_in);
        cyc(20'h08000, 1'b1);
        chk("prompt ready", 16'h1, 16'(md > 3 && md < 10));
        $display("wait test done");
    endtask

    task automatic t_upper;
        aux(7'h04, 2'b00, 3'b100);
        cyc(20'h30004, 1'b1);
        chk("address pins", 16'h2, 16'(up));
        pbase <= 9'h100;
        pbv <= 1'b1;
        aux(7'h04, 2'b11, 3'b110);
        cyc(20'h80500, 1'b1);
        chk("fifth select", 16'h2, 16'(up));
        chk("upper waits", 16'h5, 16'(ud));
        cyc(20'h80600, 1'b1);
        chk("sixth select", 16'h1, 16'(up));
        cyc(20'h80500, 1'b0);
        chk("io not mapped", 16'h3, 16'(up));
        pbase <= 9'h010;
        aux(7'h04, 2'b10, 3'b100);
        cyc(20'h08500, 1'b0);
        chk("io fifth", 16'h2, 16'(up));
        chk("upper no wait", 16'h3, 16'(ud));
        cyc(20'h08500, 1'b1);
        chk("memory not mapped", 16'h3, 16'(up));
        chk("lower off", 16'h0, 16'(lse));
        @(posedge mclk_in);
        lcw <= 1'b1;
        @(posedge mclk_in);
        lcw <= 1'b0;
        @(negedge mclk_in);
        chk("lower on", 16'h1, 16'(lse));
        $display("upper select test done");
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Whole run is near 1000 cycles, so this only trips on a hang
    initial begin
        repeat (20000) @(posedge mclk_in);
        fail_count++;
        close_out();
    end

    initial begin
        {wr, rd, cs, cm, ce, frz, pbv, lcw} = 8'h00;
        {ra, wd, ca, pbase, dly} = '0;
        rst_in = 1'b1;
        repeat (10) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_reset();
        t_sizes();
        t_full();
        t_waits();
        t_upper();
        close_out();
    end
endmodule // mcsd_decode_tb_top
`default_nettype wire

// [tb/mcsd_partner.sv]
// Behavioural memory device answering the midrange selects with ready
`timescale 1ns/1ps
`default_nettype none

module mcsd_partner (
    input wire logic mclk_in,        // System clock
    input wire logic rst_in,         // Async reset, active high
    input wire logic [3:0] sel_n_in, // Midrange selects, active low
    input wire logic [3:0] delay_in, // Access time in cycles
    output logic ready_out           // Ready back to the block
);
    logic [3:0] cnt_reg;

    // ready only after the access time
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg <= 4'h0;
        end else if (&sel_n_in) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'hF) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    // select pins reach the model directly, as with the pin mux in select use
    // Ready drops at once when deselected, so a stale high never leaks
    assign ready_out = !(&sel_n_in) && (cnt_reg >= delay_in);
endmodule // mcsd_partner
`default_nettype wire

// [verilog/mcsd_decode.sv]
// Midrange chip select decoder with auxiliary select register
`timescale 1ns/1ps
`default_nettype none

module mcsd_decode (
    input wire logic mclk_in,                   // 10 MHz system clock
    input wire logic rst_in,                    // Async reset, active high
    input wire logic [7:0] reg_addr_in,         // Register address
    input wire logic [15:0] reg_wdata_in,       // Register write data
    input wire logic reg_wr_in,                 // Write strobe
    input wire logic reg_rd_in,                 // Read strobe
    output logic [15:0] reg_rdata_out,          // Read data, cycle after strobe
    input wire logic cyc_start_in,              // Bus cycle address phase pulse
    input wire logic [19:0] cyc_addr_in,        // Non-muxed address at start
    input wire logic cyc_mem_in,                // 1 memory cycle, 0 I/O cycle
    input wire logic cyc_end_in,                // Bus cycle end pulse
    input wire logic full_range_select_zero_in, // System configuration bit
    input wire logic [8:0] peripheral_base_in,  // Peripheral base bits 19..11
    input wire logic peripheral_base_valid_in,  // Peripheral base written
    input wire logic lower_config_write_in,     // Lower select config written
    input wire logic ext_ready_in,              // External ready pin
    output logic [3:0] midrange_selects_n_out,  // Midrange selects, active low
    output logic [1:0] upper_peripheral_selects_out, // [1] sixth, [0] fifth
    output logic lower_select_enable_out,       // Lower memory select enabled
    output logic mid_done_out,                  // Midrange cycle may finish
    output logic upper_done_out                 // Upper peripheral cycle may finish
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic block_hit(input logic [19:0] addr, input logic [6:0] code,
                                       input logic [6:0] base);
        logic [19:0] size;
        logic [19:0] mask;
        size = {code, mcsd_pkg::MCSD_BASE_PAD};
        mask = ~(size - 20'h00001);
        block_hit = (code != 7'h00) &&
                    (((addr ^ {base, mcsd_pkg::MCSD_BASE_PAD}) & mask) == 20'h00000);
    endfunction

    function automatic logic [1:0] quarter_of(input logic [19:0] addr,
                                              input logic [6:0] code);
        quarter_of = 2'h0;
        for (int i = 0; i < 7; i++) begin
            if (code[i]) begin
                quarter_of = addr[12 + i -: 2];
            end
        end
    endfunction

    function automatic logic slot_hit(input logic [19:0] addr, input logic mem,
                                      input logic [8:0] pbase, input logic [11:0] slot);
        logic [19:0] eff;
        logic [19:0] off;
        eff = mem ? addr : {4'h0, addr[15:0]};
        off = eff - {pbase, mcsd_pkg::MCSD_PBASE_PAD};
        slot_hit = (off[19:8] == slot);
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] mid_ctrl_reg;
    logic [15:0] aux_ctrl_reg;
    logic mid_written_reg;
    logic aux_written_reg;
    logic [19:0] lat_addr_reg;
    logic lat_mem_reg;
    logic stage_reg;
    logic [15:0] rdata_next;
    logic ready_sync;

    logic wr_mid;
    logic wr_aux;
    assign wr_mid = reg_wr_in && (reg_addr_in == mcsd_pkg::MCSD_MID_OFF);
    assign wr_aux = reg_wr_in && (reg_addr_in == mcsd_pkg::MCSD_AUX_OFF);

    // Reserved bits are stored as written so software sees its own value back
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            mid_ctrl_reg <= mcsd_pkg::MCSD_MID_RST;
            aux_ctrl_reg <= mcsd_pkg::MCSD_AUX_RST;
        end else begin
            if (wr_mid) begin
                mid_ctrl_reg <= reg_wdata_in;
            end
            if (wr_aux) begin
                aux_ctrl_reg <= reg_wdata_in;
            end
        end
    end

    // RULE7: arming flags
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            mid_written_reg <= 1'b0;
            aux_written_reg <= 1'b0;
        end else begin
            if (wr_mid) begin
                mid_written_reg <= 1'b1;
            end
            if (wr_aux) begin
                aux_written_reg <= 1'b1;
            end
        end
    end

    // RULE18: lower select arming
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lower_select_enable_out <= 1'b0;
        end else if (lower_config_write_in) begin
            lower_select_enable_out <= 1'b1;
        end
    end

    logic [6:0] size_code;
    logic [6:0] mid_base;
    logic mid_active;
    logic upper_cs_active;
    logic pin_cs_mode;
    logic space_mem;
    assign size_code = aux_ctrl_reg[mcsd_pkg::MCSD_SIZE_MSB:mcsd_pkg::MCSD_SIZE_LSB];
    assign mid_base = mid_ctrl_reg[mcsd_pkg::MCSD_BASE_MSB:mcsd_pkg::MCSD_BASE_LSB];
    assign mid_active = mid_written_reg && aux_written_reg;
    assign pin_cs_mode = aux_ctrl_reg[mcsd_pkg::MCSD_EX_BIT];
    assign space_mem = aux_ctrl_reg[mcsd_pkg::MCSD_MS_BIT];
    assign upper_cs_active = aux_written_reg && peripheral_base_valid_in && pin_cs_mode;

    always_comb begin
        rdata_next = 16'h0000;
        if (reg_addr_in == mcsd_pkg::MCSD_MID_OFF) begin
            rdata_next = mid_ctrl_reg;
        end else if (reg_addr_in == mcsd_pkg::MCSD_AUX_OFF) begin
            rdata_next = aux_ctrl_reg;
        end else if (reg_addr_in == mcsd_pkg::MCSD_STAT_OFF) begin
            rdata_next = {11'h000, lower_select_enable_out, upper_cs_active, mid_active,
                          aux_written_reg, mid_written_reg};
        end
    end

    // Unmapped addresses read as zero
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_next;
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Bus cycle capture
    // ------------------------------------------------------------------
    // The capture stage stands for the half-cycle lag of the muxed address
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lat_addr_reg <= 20'h00000;
            lat_mem_reg <= 1'b0;
            stage_reg <= 1'b0;
        end else begin
            stage_reg <= cyc_start_in;
            if (cyc_start_in) begin
                lat_addr_reg <= cyc_addr_in;
                lat_mem_reg <= cyc_mem_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // Midrange selects
    // ------------------------------------------------------------------
    logic mid_hit;
    logic [1:0] mid_quarter;
    logic [3:0] sel_next;
    logic mid_go;

    // RULE1: block size and base match
    // RULE4: base bits 19..13 only
    assign mid_hit = mid_active && lat_mem_reg && block_hit(lat_addr_reg, size_code, mid_base);
    // RULE2: quarter select
    assign mid_quarter = quarter_of(lat_addr_reg, size_code);
    assign mid_go = stage_reg && mid_hit && !cyc_end_in;

    always_comb begin
        sel_next = 4'hF;
        if (mid_hit) begin
            sel_next[mid_quarter] = 1'b0;
            // RULE9: select zero over whole block
            if (full_range_select_zero_in) begin
                sel_next[0] = 1'b0;
            end
        end
    end

    // RULE8: assert at muxed-bus stage
    // RULE19: released at cycle end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            midrange_selects_n_out <= 4'hF;
        end else if (cyc_end_in) begin
            midrange_selects_n_out <= 4'hF;
        end else if (stage_reg) begin
            midrange_selects_n_out <= sel_next;
        end
    end

    // ------------------------------------------------------------------
    // Upper peripheral pins
    // ------------------------------------------------------------------
    logic [1:0] upper_hit;
    logic upper_go;

    // RULE15: memory or I/O space
    assign upper_hit[0] = upper_cs_active && (lat_mem_reg == space_mem) &&
                          slot_hit(lat_addr_reg, lat_mem_reg, peripheral_base_in,
                                   mcsd_pkg::MCSD_SLOT5);
    assign upper_hit[1] = upper_cs_active && (lat_mem_reg == space_mem) &&
                          slot_hit(lat_addr_reg, lat_mem_reg, peripheral_base_in,
                                   mcsd_pkg::MCSD_SLOT6);
    assign upper_go = stage_reg && (upper_hit != 2'b00) && !cyc_end_in;

    // RULE13: chip selects or latched A2, A1
    // RULE14: aux write alone arms address mode
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            upper_peripheral_selects_out <= 2'b11;
        end else if (!aux_written_reg) begin
            upper_peripheral_selects_out <= 2'b11;
        end else if (wr_aux && !pin_cs_mode && reg_wdata_in[mcsd_pkg::MCSD_EX_BIT]) begin
            // Leaving address mode must not leave a stale low level posing as a select
            upper_peripheral_selects_out <= 2'b11;
        end else if (!pin_cs_mode) begin
            if (stage_reg) begin
                upper_peripheral_selects_out <= {lat_addr_reg[2], lat_addr_reg[1]};
            end
        end else if (cyc_end_in) begin
            upper_peripheral_selects_out <= 2'b11;
        end else if (stage_reg) begin
            upper_peripheral_selects_out <= ~upper_hit;
        end
    end

    // ------------------------------------------------------------------
    // Ready and wait states
    // ------------------------------------------------------------------
    mcsd_sync u_ready_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .async_in(ext_ready_in),
        .sync_out(ready_sync)
    );

    // RULE11: midrange ready mode and waits
    mcsd_wait u_mid_wait (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .start_in(mid_go),
        .abort_in(cyc_end_in),
        .wait_states_in(mid_ctrl_reg[mcsd_pkg::MCSD_WS_MSB:mcsd_pkg::MCSD_WS_LSB]),
        .ready_ignore_in(mid_ctrl_reg[mcsd_pkg::MCSD_RDY_BIT]),
        .ready_in(ready_sync),
        .done_out(mid_done_out)
    );

    // RULE16: aux ready and waits for upper pins
    mcsd_wait u_upper_wait (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .start_in(upper_go),
        .abort_in(cyc_end_in),
        .wait_states_in(aux_ctrl_reg[mcsd_pkg::MCSD_WS_MSB:mcsd_pkg::MCSD_WS_LSB]),
        .ready_ignore_in(aux_ctrl_reg[mcsd_pkg::MCSD_RDY_BIT]),
        .ready_in(ready_sync),
        .done_out(upper_done_out)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    a_mid_stay_off: assert property ( // RULE7
        !(mid_written_reg && aux_written_reg) |-> midrange_selects_n_out == 4'hF)
        else $error("midrange select active before both registers written");

    a_mid_lag_start: assert property ( // RULE8
        (midrange_selects_n_out != 4'hF && $past(midrange_selects_n_out) == 4'hF)
        |-> $past(cyc_start_in, 2))
        else $error("midrange select did not follow start by two cycles");

    a_mid_quarter_onehot: assert property ( // RULE2
        (!$past(full_range_select_zero_in) && midrange_selects_n_out != 4'hF)
        |-> $onehot(~midrange_selects_n_out))
        else $error("more than one quarter select active");

    a_mid_in_block: assert property ( // RULE1
        (midrange_selects_n_out != 4'hF)
        |-> block_hit(lat_addr_reg, size_code, mid_base) && lat_mem_reg)
        else $error("midrange select outside configured block");

    a_mid_zero_full: assert property ( // RULE9
        ($past(full_range_select_zero_in) && midrange_selects_n_out[3:1] != 3'h7)
        |-> !midrange_selects_n_out[0])
        else $error("select zero missing in full range mode");

    a_mid_end_release: assert property ( // RULE19
        cyc_end_in |=> midrange_selects_n_out == 4'hF)
        else $error("midrange select held past cycle end");

    a_mid_wait_three: assert property ( // RULE11
        (mid_go && mid_ctrl_reg[1:0] == 2'h3 && mid_ctrl_reg[2]) ##1 !cyc_end_in[*4]
        |-> !mid_done_out ##1 mid_done_out)
        else $error("midrange done not five cycles after start");

    a_mid_wait_exact: assert property ( // RULE11
        (mid_go && mid_ctrl_reg[1:0] == 2'h0 && mid_ctrl_reg[2]) ##1 !cyc_end_in
        |-> ##1 mid_done_out)
        else $error("midrange done not two cycles after start");

    a_upper_addr_mode: assert property ( // RULE13
        (aux_written_reg && !pin_cs_mode && $past(stage_reg) && $past(aux_written_reg)
         && !$past(pin_cs_mode))
        |-> upper_peripheral_selects_out == {$past(lat_addr_reg[2]), $past(lat_addr_reg[1])})
        else $error("upper pins not showing latched address bits");

    a_upper_need_aux: assert property ( // RULE14
        !aux_written_reg |-> upper_peripheral_selects_out == 2'b11)
        else $error("upper pins active before auxiliary write");

    a_upper_space: assert property ( // RULE15
        (pin_cs_mode && upper_peripheral_selects_out != 2'b11 && $past(pin_cs_mode))
        |-> lat_mem_reg == space_mem)
        else $error("upper select in wrong bus space");

    a_upper_wait_zero: assert property ( // RULE16
        (upper_go && aux_ctrl_reg[1:0] == 2'h0 && aux_ctrl_reg[2]) ##1 !cyc_end_in
        |-> ##1 upper_done_out)
        else $error("upper done not two cycles after start");

    a_lower_arm: assert property ( // RULE18
        lower_config_write_in |=> lower_select_enable_out)
        else $error("lower select not enabled after config write");

endmodule // mcsd_decode

`default_nettype wire

// [verilog/mcsd_pkg.sv]
// Constants for the midrange chip select decoder and its auxiliary register
// Operation
// RULE1: One-hot size code bits 14..8 give block 8K (bit 8) doubling up to 512K.
// RULE2: Block splits into four equal quarters, one midrange select per quarter.
// RULE3: Software sets exactly one size bit; otherwise select behaviour is unpredictable.
// RULE4: Base bits 19..13 come from register bits 15..9; base bits 12..0 are zero.
// RULE5: Software places the base only on a multiple of the block size.
// RULE6: Block at zero only with lower select and low bank off; 512K only at zero.
// RULE7: Midrange selects stay off after reset until both control registers are written.
// RULE8: Midrange selects assert with muxed-bus timing, half a cycle after upper/lower selects; here the upper selects assert in the same cycle.
// RULE9: With full-range bit set, select zero covers the whole block; others keep quarters.
// RULE10: Software keeps the block clear of upper, lower and memory-mapped peripheral ranges.
// RULE11: Midrange ready bit 0 waits for external ready, 1 ignores it; plus 0-3 waits.
// RULE12: Software clears programmable I/O mode and direction for the four select pins.
// RULE13: Aux bit 7 set gives upper peripheral chip selects; clear gives latched A1, A2.
// RULE14: In address mode an auxiliary write alone activates the upper peripheral pins.
// RULE15: Aux bit 6 set answers memory cycles, clear answers I/O cycles.
// RULE16: Aux ready bit and wait field govern only the upper peripheral selects.
// RULE17: Software writes ones to all reserved bits of both registers.
// RULE18: Lower memory select is off after reset and turns on at any config write.
// RULE19: Midrange selects are active low, only in memory cycles hitting their quarter; with full-range set, select zero asserts across the whole block.

package mcsd_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] MCSD_MID_OFF = 8'hA6;
    localparam logic [7:0] MCSD_AUX_OFF = 8'hA8;
    localparam logic [7:0] MCSD_STAT_OFF = 8'hAA;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MCSD_BASE_MSB = 15;
    localparam int MCSD_BASE_LSB = 9;
    localparam int MCSD_SIZE_MSB = 14;
    localparam int MCSD_SIZE_LSB = 8;
    localparam int MCSD_EX_BIT = 7;
    localparam int MCSD_MS_BIT = 6;
    localparam int MCSD_RDY_BIT = 2;
    localparam int MCSD_WS_MSB = 1;
    localparam int MCSD_WS_LSB = 0;

    // ------------------------------------------------------------------
    // Reset values (reserved bits held at one)
    // ------------------------------------------------------------------
    localparam logic [15:0] MCSD_MID_RST = 16'h01F8;
    localparam logic [15:0] MCSD_AUX_RST = 16'h8038;

    // ------------------------------------------------------------------
    // Address arithmetic
    // ------------------------------------------------------------------
    localparam logic [12:0] MCSD_BASE_PAD = 13'h0000;
    localparam logic [10:0] MCSD_PBASE_PAD = 11'h000;
    localparam logic [11:0] MCSD_SLOT5 = 12'h005;
    localparam logic [11:0] MCSD_SLOT6 = 12'h006;

endpackage : mcsd_pkg

// [verilog/mcsd_sync.sv]
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
`default_nettype none

module mcsd_sync (
    input wire logic mclk_in,   // System clock
    input wire logic rst_in,    // Async reset, active high
    input wire logic async_in,  // Pin level
    output logic sync_out       // Filtered level
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Change only counts once the last two stages agree
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_out <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            sync_out <= s3_reg;
        end
    end

endmodule // mcsd_sync

`default_nettype wire

// [verilog/mcsd_wait.sv]
// Wait-state counter with optional external ready for one select group
`timescale 1ns/1ps
`default_nettype none

module mcsd_wait (
    input wire logic mclk_in,             // System clock
    input wire logic rst_in,              // Async reset, active high
    input wire logic start_in,            // Select just asserted
    input wire logic abort_in,            // Bus cycle ended
    input wire logic [1:0] wait_states_in, // Wait states 0..3
    input wire logic ready_ignore_in,     // 1 ignores external ready
    input wire logic ready_in,            // Synchronised external ready
    output logic done_out                 // One-cycle completion pulse
);

    logic busy_reg;
    logic [1:0] count_reg;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_reg <= 1'b0;
            count_reg <= 2'h0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                busy_reg <= 1'b1;
                count_reg <= wait_states_in;
            end else if (abort_in) begin
                busy_reg <= 1'b0;
            end else if (busy_reg) begin
                if (count_reg != 2'h0) begin
                    count_reg <= count_reg - 2'h1;
                end else if (ready_ignore_in || ready_in) begin
                    // Counted waits first, then external ready if required
                    done_out <= 1'b1;
                    busy_reg <= 1'b0;
                end
            end
        end
    end

endmodule // mcsd_wait

`default_nettype wire
